// ==== dv/pcm_client_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcm_client_model #(
  parameter int unsigned WORK_CYCLES = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Work requests from the bench
  input wire logic gui_req_i,
  input wire logic host_req_i,
  // Block side
  input wire logic gui_refuse_i,
  input wire logic host_refuse_i,
  input wire pcm_pkg::pcm_op_t maint_op_i,
  output logic gui_busy_o,
  output logic host_busy_o,
  output logic dirty_o
);
  import pcm_pkg::*;
  logic [3:0] gui_cnt;
  logic [3:0] host_cnt;
  pcm_op_t last_op;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gui_cnt <= 4'h0;
      host_cnt <= 4'h0;
      dirty_o <= 1'b0;
      last_op <= PCM_OP_IDLE;
    end else begin
      last_op <= maint_op_i;
      // A refused request is dropped, never held over for later
      if (gui_cnt != 4'h0) begin
        gui_cnt <= gui_cnt - 4'h1;
      end else if (gui_req_i && !gui_refuse_i) begin
        gui_cnt <= 4'(WORK_CYCLES);
        dirty_o <= 1'b1;
      end
      if (host_cnt != 4'h0) begin
        host_cnt <= host_cnt - 4'h1;
      end else if (host_req_i && !host_refuse_i) begin
        host_cnt <= 4'(WORK_CYCLES);
      end
      // Only a finished write-back or purge leaves the store clean
      if (last_op inside {PCM_OP_WB, PCM_OP_CLR} && maint_op_i == PCM_OP_IDLE) begin
        dirty_o <= 1'b0;
      end
    end
  end
  assign gui_busy_o = gui_cnt != 4'h0;
  assign host_busy_o = host_cnt != 4'h0;
endmodule : pcm_client_model
`default_nettype wire

// ==== dv/pcm_ctl_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pcm_defs.svh"
module pcm_ctl_bench;
  import pcm_pkg::*;
  localparam logic [15:0] HA = `PCM_ADDR_HOST_CTLSTAT;
  localparam logic [15:0] GA = `PCM_ADDR_GUI_CTLSTAT;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic rise_en = 1'b1;
  logic fall_en = 1'b0;
  logic clr_en = 1'b1;
  logic bypass = 1'b0;
  logic wb_trig = 1'b0;
  logic clr_trig = 1'b0;
  logic gui_req = 1'b0;
  logic host_req = 1'b0;
  logic gui_busy, host_busy, dirty, gui_act, gui_ref, host_ref;
  pcm_op_t op;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  always #4 clk_i = ~clk_i;
  // Short counts keep the run brief; every expectation allows for them
  pcm_ctl #(.OP_CYCLES(8), .INIT_CYCLES(16)) i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .writeback_rise_trigger_en_i(rise_en), .writeback_fall_trigger_en_i(fall_en),
    .clear_all_rise_trigger_en_i(clr_en), .storage_bypass_en_i(bypass),
    .writeback_trigger_in_i(wb_trig), .clear_all_trigger_in_i(clr_trig),
    .gui_client_busy_i(gui_busy), .host_client_busy_i(host_busy),
    .modified_data_present_i(dirty), .gui_active_out_o(gui_act),
    .gui_refuse_o(gui_ref), .host_refuse_o(host_ref), .maint_op_o(op));
  pcm_client_model i_clients (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .gui_req_i(gui_req), .host_req_i(host_req),
    .gui_refuse_i(gui_ref), .host_refuse_i(host_ref), .maint_op_i(op),
    .gui_busy_o(gui_busy), .host_busy_o(host_busy), .dirty_o(dirty));
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input string what, input logic [15:0] a, input logic [31:0] e);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    chk(what, e, rdata);
  endtask : rd_reg
  // Written through one image, status read back through the other, idle state through the same one
  task automatic run_op(input string what, input logic [15:0] a, input logic [31:0] cmd,
                        input logic [31:0] stat, input logic [1:0] refs, input pcm_op_t eop);
    wr_reg(a, cmd);
    rd_reg(what, (a == GA) ? HA : GA, stat);
    chk(what, refs, {gui_ref, host_ref});
    chk(what, eop, op);
    chk(what, stat[29], gui_act);
    tick(20);
    rd_reg(what, a, {7'h00, dirty, 24'h00_0000});
    chk(what, 3'h0, {gui_act, gui_ref, host_ref});
  endtask : run_op
  task automatic t_reset;
    rd_reg("init", GA, 32'h8800_0000);
    tick(30);
    rd_reg("idle", HA, 32'h0000_0000);
    rd_reg("diag", `PCM_ADDR_DIAG, 32'h0000_0000);
    rd_reg("unmapped", 16'h0188, 32'h0000_0000);
    wr_reg(GA, 32'h0000_0000);
    rd_reg("zero write", GA, 32'h0000_0000);
    $display("reset test done");
  endtask : t_reset
  task automatic t_ops;
    for (int c = 1; c < 4; c++) begin
      run_op("flush", GA, 32'(c), 32'hB000_0000 | 32'(c), 2'b00, PCM_OP_WB);
    end
    run_op("host flush", HA, 32'h30, 32'hD000_0030, 2'b00, PCM_OP_WB);
    run_op("joint flush", GA, 32'h33, 32'hF000_0033, 2'b00, PCM_OP_WB);
    run_op("gui inv", HA, 32'h04, 32'hB000_0004, 2'b10, PCM_OP_INV);
    run_op("host inv", GA, 32'h40, 32'hD000_0040, 2'b01, PCM_OP_INV);
    run_op("joint inv", HA, 32'hCC, 32'hF000_00CC, 2'b11, PCM_OP_INV);
    run_op("gui purge", GA, 32'h100, 32'hB000_0100, 2'b00, PCM_OP_CLR);
    run_op("host purge", HA, 32'h200, 32'hD000_0200, 2'b00, PCM_OP_CLR);
    wr_reg(GA, 32'h3);
    tick(4);
    wr_reg(GA, 32'h1);
    tick(4);
    rd_reg("restart", GA, 32'hB000_0003);
    tick(16);
    wr_reg(HA, 32'h10);
    tick(2);
    wr_reg(GA, 32'h1);
    tick(4);
    rd_reg("late gui", GA, 32'hF000_0011);
    tick(16);
    wr_reg(GA, 32'h3);
    tick(2);
    run_op("purge on flush", HA, 32'h100, 32'hB000_0103, 2'b00, PCM_OP_CLR);
    $display("operation test done");
  endtask : t_ops
  task automatic trig(input string what, input logic w, input logic c, input logic [31:0] e);
    @(posedge clk_i);
    wb_trig <= w;
    clr_trig <= c;
    rd_reg(what, GA, e);
    tick(20);
    rd_reg(what, HA, 32'h0000_0000);
  endtask : trig
  task automatic t_trig;
    trig("in purge", 1'b0, 1'b1, 32'h1200_0000);
    trig("purge fall", 1'b0, 1'b0, 32'h0000_0000);
    trig("in flush", 1'b1, 1'b0, 32'h9400_0000);
    trig("fall off", 1'b0, 1'b0, 32'h0000_0000);
    @(posedge clk_i);
    rise_en <= 1'b0;
    fall_en <= 1'b1;
    trig("rise off", 1'b1, 1'b0, 32'h0000_0000);
    trig("fall on", 1'b0, 1'b0, 32'h9400_0000);
    @(posedge clk_i);
    bypass <= 1'b1;
    rise_en <= 1'b1;
    trig("bypass", 1'b1, 1'b1, 32'h0000_0000);
    trig("bypass low", 1'b0, 1'b0, 32'h0000_0000);
    @(posedge clk_i);
    bypass <= 1'b0;
    wb_trig <= 1'b1;
    tick(2);
    wr_reg(GA, 32'h3);
    rd_reg("sw on input", GA, 32'hB400_0003);
    tick(2);
    rd_reg("sw restart", HA, 32'hB400_0003);
    tick(20);
    rd_reg("sw on input", GA, 32'h0000_0000);
    $display("trigger test done");
  endtask : t_trig
  task automatic t_clients;
    @(posedge clk_i);
    host_req <= 1'b1;
    @(posedge clk_i);
    host_req <= 1'b0;
    rd_reg("host work", GA, 32'hC000_0000);
    tick(10);
    @(posedge clk_i);
    gui_req <= 1'b1;
    @(posedge clk_i);
    gui_req <= 1'b0;
    rd_reg("gui work", HA, 32'hA100_0000);
    chk("gui out", 1'b1, gui_act);
    tick(10);
    rd_reg("dirty idle", GA, 32'h0100_0000);
    run_op("dirty flush", GA, 32'h3, 32'hB100_0003, 2'b00, PCM_OP_WB);
    wr_reg(GA, 32'h4);
    @(posedge clk_i);
    gui_req <= 1'b1;
    @(posedge clk_i);
    gui_req <= 1'b0;
    @(negedge clk_i);
    chk("refused", 1'b0, gui_busy);
    tick(20);
    $display("client test done");
  endtask : t_clients
  initial begin
    tick(10);
    rst_b_i <= 1'b1;
    t_reset();
    t_ops();
    t_trig();
    t_clients();
    finish_test();
  end
endmodule : pcm_ctl_bench
`default_nettype wire

// ==== rtl/pcm_ctl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pcm_defs.svh"

// Summary of operation
// RULE1 - Flush field 11 writes back all dirty data; 01 or 10 one channel only
// RULE2 - Flushes never refuse GUI or host client operations
// RULE3 - Flush bits read one until done, then self-clear; GUI flush drives GUI busy
// RULE4 - Writing zeros does nothing; rewriting a set flush bit restarts the counter
// RULE5 - GUI and host flush written together run one flush shown in both
// RULE6 - GUI flush set while host flush pending restarts counter, runs as combined
// RULE7 - Software flush during input flush restarts counter; input flush bit stays
// RULE8 - Invalidate marks all data invalid, self-clears, refuses new GUI operations
// RULE9 - Rewrite restarts invalidate counter; combined invalidate refuses all clients
// RULE10 - Host fields mirror GUI ones, raising host busy and refusing host operations
// RULE11 - Purge writes back, invalidates, deallocates; GUI or host busy per bit
// RULE12 - Purge requested during flush or invalidate restarts that operation as purge
// RULE13 - Dirty status reads one while modified data is held; resets to zero
// RULE14 - Purge input rising edge starts purge, shown in status; restarts running op
// RULE15 - Flush input edge starts flush, shown in status; restarts running flush
// RULE16 - An init cycle runs right after reset release, shown in init status
// RULE17 - Maintenance busy reads one while any flush, invalidate or purge runs
// RULE18 - GUI busy covers GUI client work, GUI flush and GUI invalidate
// RULE19 - Host busy covers host client work, host flush and host invalidate
// RULE20 - Overall busy is OR of init, GUI, host busy and input flush status
// RULE21 - Writes act at once; reads return live status with no side effects
// RULE22 - Static enables pick trigger edges; bypass mode ignores all trigger edges
// RULE23 - Both register images show and drive the same command and status state
module pcm_ctl #(
  parameter int unsigned OP_CYCLES = `PCM_OP_CYCLES,
  parameter int unsigned INIT_CYCLES = `PCM_INIT_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  // Static mode settings
  input wire logic writeback_rise_trigger_en_i,
  input wire logic writeback_fall_trigger_en_i,
  input wire logic clear_all_rise_trigger_en_i,
  input wire logic storage_bypass_en_i,
  // Trigger inputs from other logic
  input wire logic writeback_trigger_in_i,
  input wire logic clear_all_trigger_in_i,
  // Datapath and client status
  input wire logic gui_client_busy_i,
  input wire logic host_client_busy_i,
  input wire logic modified_data_present_i,
  // Status and control outputs
  output logic gui_active_out_o,
  output logic gui_refuse_o,
  output logic host_refuse_o,
  output pcm_pkg::pcm_op_t maint_op_o
);
  import pcm_pkg::*;

  localparam logic [15:0] OP_LAST = 16'(OP_CYCLES - 1);
  localparam logic [15:0] INIT_LAST = 16'(INIT_CYCLES - 1);

  pcm_state_t s;
  pcm_state_t next_s;
  logic wr_hit;
  logic restart;
  logic done;
  logic wb_edge;
  logic clr_edge;

  // Both images decode to the same state
  function automatic logic is_ctl(input logic [15:0] a);
    is_ctl = (a == `PCM_ADDR_GUI_CTLSTAT) || (a == `PCM_ADDR_HOST_CTLSTAT); // [RULE23]
  endfunction : is_ctl

  // Strongest pending request wins; a purge covers flush and invalidate
  function automatic pcm_op_t pick_op(input pcm_state_t st);
    if (st.gui_clr || st.host_clr || st.in_clr) begin
      pick_op = PCM_OP_CLR; // [RULE12]
    end else if ((|st.gui_inv) || (|st.host_inv)) begin
      pick_op = PCM_OP_INV;
    end else if ((|st.gui_wb) || (|st.host_wb) || st.in_wb) begin
      pick_op = PCM_OP_WB;
    end else begin
      pick_op = PCM_OP_IDLE;
    end
  endfunction : pick_op

  function automatic logic gui_busy(input pcm_state_t st, input logic client);
    gui_busy = client || (|st.gui_wb) || (|st.gui_inv) || st.gui_clr; // [RULE18] [RULE3]
  endfunction : gui_busy

  function automatic logic host_busy(input pcm_state_t st, input logic client);
    host_busy = client || (|st.host_wb) || (|st.host_inv) || st.host_clr; // [RULE19] [RULE10]
  endfunction : host_busy

  // Live status image; reserved bits read as zero
  function automatic logic [31:0] image(input pcm_state_t st, input logic gc, input logic hc);
    logic [31:0] v;
    v = `PCM_CTLSTAT_RESET;
    v[`PCM_GUI_WB_LSB +: 2] = st.gui_wb;
    v[`PCM_GUI_INV_LSB +: 2] = st.gui_inv;
    v[`PCM_HOST_WB_LSB +: 2] = st.host_wb;
    v[`PCM_HOST_INV_LSB +: 2] = st.host_inv;
    v[`PCM_GUI_CLR_BIT] = st.gui_clr;
    v[`PCM_HOST_CLR_BIT] = st.host_clr;
    v[`PCM_DIRTY_BIT] = st.dirty; // [RULE13]
    v[`PCM_IN_CLR_BIT] = st.in_clr; // [RULE14]
    v[`PCM_IN_WB_BIT] = st.in_wb; // [RULE15]
    v[`PCM_INIT_BIT] = st.init; // [RULE16]
    v[`PCM_MAINT_BIT] = (st.op != PCM_OP_IDLE); // [RULE17]
    v[`PCM_GUI_BUSY_BIT] = gui_busy(st, gc);
    v[`PCM_HOST_BUSY_BIT] = host_busy(st, hc);
    v[`PCM_ANY_BUSY_BIT] = st.init || gui_busy(st, gc) || host_busy(st, hc) || st.in_wb; // [RULE20]
    image = v;
  endfunction : image

  always_comb begin
    next_s = s;
    restart = 1'b0;
    wr_hit = reg_wr_i && is_ctl(reg_addr_i);
    // Init runs first; queued work waits so it starts on clean tags
    if (s.init) begin
      if (s.init_cnt == INIT_LAST) begin
        next_s.init = 1'b0; // [RULE16]
      end else begin
        next_s.init_cnt = s.init_cnt + 16'h0001;
      end
    end
    done = !s.init && (s.op != PCM_OP_IDLE) && (s.op_cnt == OP_LAST);
    if (done) begin
      case (s.op)
        PCM_OP_CLR: begin
          next_s.gui_wb = 2'h0;
          next_s.host_wb = 2'h0;
          next_s.gui_inv = 2'h0;
          next_s.host_inv = 2'h0;
          next_s.gui_clr = 1'b0;
          next_s.host_clr = 1'b0;
          next_s.in_wb = 1'b0;
          next_s.in_clr = 1'b0; // [RULE11]
        end
        PCM_OP_INV: begin
          next_s.gui_inv = 2'h0;
          next_s.host_inv = 2'h0; // [RULE8] [RULE9]
        end
        PCM_OP_WB: begin
          next_s.gui_wb = 2'h0;
          next_s.host_wb = 2'h0;
          next_s.in_wb = 1'b0; // [RULE3] [RULE5] [RULE7]
        end
        default: begin
        end
      endcase
      next_s.op_cnt = 16'h0000;
    end else if (!s.init && (s.op != PCM_OP_IDLE)) begin
      next_s.op_cnt = s.op_cnt + 16'h0001;
    end
    // Trigger edges; bypass means nothing is cached, so nothing to maintain
    next_s.trig_wb_q = writeback_trigger_in_i;
    next_s.trig_clr_q = clear_all_trigger_in_i;
    wb_edge = !storage_bypass_en_i &&
      ((writeback_rise_trigger_en_i && writeback_trigger_in_i && !s.trig_wb_q) ||
       (writeback_fall_trigger_en_i && !writeback_trigger_in_i && s.trig_wb_q)); // [RULE22]
    clr_edge = !storage_bypass_en_i && clear_all_rise_trigger_en_i &&
      clear_all_trigger_in_i && !s.trig_clr_q; // [RULE22]
    if (wb_edge) begin
      next_s.in_wb = 1'b1;
      restart = 1'b1; // [RULE15]
    end
    if (clr_edge) begin
      next_s.in_clr = 1'b1;
      restart = 1'b1; // [RULE14]
    end
    // Sets are applied after completion clears, so a set in the same cycle wins
    if (wr_hit) begin
      next_s.gui_wb = next_s.gui_wb | reg_wdata_i[`PCM_GUI_WB_LSB +: 2]; // [RULE1]
      next_s.gui_inv = next_s.gui_inv | reg_wdata_i[`PCM_GUI_INV_LSB +: 2]; // [RULE8]
      next_s.host_wb = next_s.host_wb | reg_wdata_i[`PCM_HOST_WB_LSB +: 2]; // [RULE10]
      next_s.host_inv = next_s.host_inv | reg_wdata_i[`PCM_HOST_INV_LSB +: 2]; // [RULE10]
      next_s.gui_clr = next_s.gui_clr | reg_wdata_i[`PCM_GUI_CLR_BIT]; // [RULE11]
      next_s.host_clr = next_s.host_clr | reg_wdata_i[`PCM_HOST_CLR_BIT]; // [RULE11]
      if (|reg_wdata_i[`PCM_HOST_CLR_BIT:0]) begin
        restart = 1'b1; // [RULE4] [RULE6] [RULE7] [RULE9] [RULE21]
      end
    end
    if (restart) begin
      next_s.op_cnt = 16'h0000; // [RULE12]
    end
    next_s.op = pick_op(next_s);
    next_s.dirty = modified_data_present_i; // [RULE13]
    // Reads are pure: only the returned word is updated
    next_s.rdata = (reg_rd_i && is_ctl(reg_addr_i)) ?
      image(s, gui_client_busy_i, host_client_busy_i) : 32'h0000_0000; // [RULE21]
    next_s.gui_out = gui_busy(next_s, gui_client_busy_i); // [RULE3]
    // Only invalidates refuse clients; flushes and purges let them through
    next_s.gui_refuse = |next_s.gui_inv; // [RULE2] [RULE8] [RULE9]
    next_s.host_refuse = |next_s.host_inv; // [RULE10]
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
      s.init <= 1'b1; // [RULE16]
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_o = s.rdata;
  assign gui_active_out_o = s.gui_out;
  assign gui_refuse_o = s.gui_refuse;
  assign host_refuse_o = s.host_refuse;
  assign maint_op_o = s.op;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_wb_hold;
    (|s.gui_wb) && (s.op_cnt != OP_LAST) |=> (|s.gui_wb);
  endproperty
  a_wb_hold: assert property (p_wb_hold) else $error("flush bit dropped early"); // [RULE3]

  property p_full_wb;
    reg_wr_i && is_ctl(reg_addr_i) && (reg_wdata_i[9:0] == 10'h003)
      |=> (s.gui_wb == 2'h3) && (s.op_cnt == 16'h0000) && (s.op != PCM_OP_IDLE);
  endproperty
  a_full_wb: assert property (p_full_wb) else $error("flush write not taken"); // [RULE1]

  property p_flush_free;
    (s.op == PCM_OP_WB) |-> !gui_refuse_o && !host_refuse_o;
  endproperty
  a_flush_free: assert property (p_flush_free) else $error("flush refused clients"); // [RULE2]

  property p_refuse;
    gui_refuse_o || host_refuse_o |-> (s.op == PCM_OP_INV) || (s.op == PCM_OP_CLR);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refuse outside invalidate"); // [RULE8]

  property p_gui_out;
    (|s.gui_wb) || (|s.gui_inv) || s.gui_clr |-> gui_active_out_o;
  endproperty
  a_gui_out: assert property (p_gui_out) else $error("gui active missing"); // [RULE18]

  property p_upgrade;
    (s.op == PCM_OP_WB) && reg_wr_i && is_ctl(reg_addr_i) && reg_wdata_i[`PCM_GUI_CLR_BIT]
      |=> (s.op == PCM_OP_CLR) && (s.op_cnt == 16'h0000);
  endproperty
  a_upgrade: assert property (p_upgrade) else $error("purge did not restart op"); // [RULE12]

  property p_wb_done;
    (s.op == PCM_OP_WB) && !s.init && (s.op_cnt == OP_LAST) && !reg_wr_i && !wb_edge
      |=> (s.gui_wb == 2'h0) && (s.host_wb == 2'h0) && !s.in_wb;
  endproperty
  a_wb_done: assert property (p_wb_done) else $error("flush did not clear"); // [RULE7]

  property p_init_end;
    s.init && (s.init_cnt == INIT_LAST) |=> !s.init;
  endproperty
  a_init_end: assert property (p_init_end) else $error("init did not end"); // [RULE16]

  property p_maint_read;
    reg_rd_i && is_ctl(reg_addr_i)
      |=> reg_rdata_o[`PCM_MAINT_BIT] == ($past(s.op) != PCM_OP_IDLE);
  endproperty
  a_maint_read: assert property (p_maint_read) else $error("maintenance bit wrong"); // [RULE17]

  property p_any_read;
    reg_rd_i && is_ctl(reg_addr_i) && (s.init || s.in_wb) |=> reg_rdata_o[`PCM_ANY_BUSY_BIT];
  endproperty
  a_any_read: assert property (p_any_read) else $error("overall busy missing"); // [RULE20]

  property p_dirty_read;
    reg_rd_i && is_ctl(reg_addr_i) |=> reg_rdata_o[`PCM_DIRTY_BIT] == $past(s.dirty);
  endproperty
  a_dirty_read: assert property (p_dirty_read) else $error("dirty bit wrong"); // [RULE13]

  property p_clr_edge;
    !storage_bypass_en_i && clear_all_rise_trigger_en_i && clear_all_trigger_in_i &&
      !s.trig_clr_q |=> s.in_clr && (s.op == PCM_OP_CLR) && (s.op_cnt == 16'h0000);
  endproperty
  a_clr_edge: assert property (p_clr_edge) else $error("purge edge missed"); // [RULE14]

  property p_bypass;
    storage_bypass_en_i && !s.in_wb |=> !s.in_wb;
  endproperty
  a_bypass: assert property (p_bypass) else $error("edge taken in bypass"); // [RULE22]

  property p_rewrite;
    (s.op == PCM_OP_WB) && wr_hit && reg_wdata_i[`PCM_GUI_WB_LSB] && s.gui_wb[0]
      |=> (s.op_cnt == 16'h0000) && s.gui_wb[0];
  endproperty
  a_rewrite: assert property (p_rewrite) else $error("rewrite did not restart flush"); // [RULE4]

  property p_host_inv;
    wr_hit && (|reg_wdata_i[`PCM_HOST_INV_LSB +: 2])
      |=> host_refuse_o && (s.op inside {PCM_OP_INV, PCM_OP_CLR});
  endproperty
  a_host_inv: assert property (p_host_inv) else $error("host invalidate not refusing"); // [RULE10]

  property p_joint_inv;
    wr_hit && (|reg_wdata_i[`PCM_GUI_INV_LSB +: 2]) &&
      ((|reg_wdata_i[`PCM_HOST_INV_LSB +: 2]) || ((|s.host_inv) && !done))
      |=> gui_refuse_o && host_refuse_o && (s.op_cnt == 16'h0000);
  endproperty
  a_joint_inv: assert property (p_joint_inv) else $error("joint invalidate not blocking"); // [RULE9]

  property p_late_gui;
    wr_hit && (|reg_wdata_i[`PCM_GUI_WB_LSB +: 2]) && (|s.host_wb) && !done
      |=> (|s.gui_wb) && (|s.host_wb) && (s.op_cnt == 16'h0000);
  endproperty
  a_late_gui: assert property (p_late_gui) else $error("late flush not combined"); // [RULE6]

  property p_wb_edge;
    wb_edge |=> s.in_wb && (s.op != PCM_OP_IDLE) && (s.op_cnt == 16'h0000);
  endproperty
  a_wb_edge: assert property (p_wb_edge) else $error("flush edge missed"); // [RULE15]

  property p_host_read;
    reg_rd_i && is_ctl(reg_addr_i) && ((|s.host_wb) || (|s.host_inv) || s.host_clr)
      |=> reg_rdata_o[`PCM_HOST_BUSY_BIT];
  endproperty
  a_host_read: assert property (p_host_read) else $error("host busy missing"); // [RULE19]

  property p_cov_combined;
    reg_wr_i && is_ctl(reg_addr_i) && (reg_wdata_i[7:0] == 8'h33);
  endproperty
  c_cov_combined: cover property (p_cov_combined);

  property p_cov_inv_done;
    (s.op == PCM_OP_INV) ##1 (s.op == PCM_OP_IDLE);
  endproperty
  c_cov_inv_done: cover property (p_cov_inv_done);

  property p_cov_input_wb;
    s.in_wb && reg_wr_i && is_ctl(reg_addr_i) && reg_wdata_i[0];
  endproperty
  c_cov_input_wb: cover property (p_cov_input_wb);

  property p_cov_upgrade;
    (s.op == PCM_OP_WB) ##1 (s.op == PCM_OP_CLR);
  endproperty
  c_cov_upgrade: cover property (p_cov_upgrade);

  property p_cov_refused;
    gui_refuse_o && host_refuse_o;
  endproperty
  c_cov_refused: cover property (p_cov_refused);

endmodule : pcm_ctl
`default_nettype wire

// ==== shared/pcm_defs.svh ====
`ifndef PCM_DEFS_SVH
`define PCM_DEFS_SVH

// Register byte addresses on the register port
`define PCM_ADDR_HOST_CTLSTAT 16'h0184
`define PCM_ADDR_GUI_CTLSTAT 16'h1748
`define PCM_ADDR_DIAG 16'h1760

// Control/status field positions (lsb)
`define PCM_GUI_WB_LSB 0
`define PCM_GUI_INV_LSB 2
`define PCM_HOST_WB_LSB 4
`define PCM_HOST_INV_LSB 6
`define PCM_GUI_CLR_BIT 8
`define PCM_HOST_CLR_BIT 9
`define PCM_DIRTY_BIT 24
`define PCM_IN_CLR_BIT 25
`define PCM_IN_WB_BIT 26
`define PCM_INIT_BIT 27
`define PCM_MAINT_BIT 28
`define PCM_GUI_BUSY_BIT 29
`define PCM_HOST_BUSY_BIT 30
`define PCM_ANY_BUSY_BIT 31

// Reset value of the control/status image
`define PCM_CTLSTAT_RESET 32'h0000_0000

// Operation lengths in clock cycles
`define PCM_OP_CYCLES 64
`define PCM_INIT_CYCLES 32

`endif

// ==== shared/pcm_pkg.sv ====
`default_nettype none
package pcm_pkg;

  // Maintenance operation kinds, ordered by precedence
  typedef enum logic [1:0] {
    PCM_OP_IDLE = 2'b00,
    PCM_OP_WB = 2'b01,
    PCM_OP_INV = 2'b10,
    PCM_OP_CLR = 2'b11
  } pcm_op_t;

  // Whole state of the maintenance controller
  typedef struct packed {
    logic [1:0] gui_wb;
    logic [1:0] gui_inv;
    logic [1:0] host_wb;
    logic [1:0] host_inv;
    logic gui_clr;
    logic host_clr;
    logic in_wb;
    logic in_clr;
    logic init;
    logic dirty;
    logic trig_wb_q;
    logic trig_clr_q;
    logic [15:0] op_cnt;
    logic [15:0] init_cnt;
    pcm_op_t op;
    logic [31:0] rdata;
    logic gui_out;
    logic gui_refuse;
    logic host_refuse;
  } pcm_state_t;

endpackage : pcm_pkg
`default_nettype wire
